// ### lbide_pkg.sv
// lbide_pkg: constants for the local-bus ide host port
// assumes: one 125 MHz clock; all inputs synchronous to it
package lbide_pkg;
    localparam logic [13:0] LBIDE_BASE_CMD = 14'h007c;   // 1f0h..1f7h, address bits 15..2
    localparam logic [13:0] LBIDE_BASE_CTL = 14'h00fd;   // 3f4h..3f7h, address bits 15..2
    localparam int LBIDE_ACTIVE_CYC = 4;                 // strobe width before ready is sampled
    localparam int LBIDE_CNT_W = 4;
    typedef enum logic [2:0] {
        LBIDE_IDLE = 3'b000,
        LBIDE_STRB = 3'b001,
        LBIDE_HI1 = 3'b010,
        LBIDE_LO = 3'b011,
        LBIDE_HI2 = 3'b100,
        LBIDE_WAIT = 3'b101
    } lbide_state_t;
endpackage

// ### lbide_lane.sv
// lbide_lane: steers one 16-bit host half onto the drive bus
// assumes: byte enables active low, selected half given by caller
`timescale 1ns/1ps
module lbide_lane (
    input wire logic [31:0] host_wdata, // host data in
    input wire logic [3:0] be_n,        // host byte enables, active low
    input wire logic upper,             // pick bits 31..16
    output logic [15:0] word,           // drive word, low byte on 7..0
    output logic any_lane               // at least one lane selected
);
    // unselected lanes give zero so they never reach the drive
    always_comb begin
        if (upper) begin
            word = {be_n[3] ? 8'h00 : host_wdata[31:24], be_n[2] ? 8'h00 : host_wdata[23:16]};
            any_lane = ~(be_n[3] & be_n[2]);
        end else begin
            word = {be_n[1] ? 8'h00 : host_wdata[15:8], be_n[0] ? 8'h00 : host_wdata[7:0]};
            any_lane = ~(be_n[1] & be_n[0]);
        end
    end
endmodule

// ### lbide_host_port.sv
// lbide_host_port: local-bus host port of an ide controller
// assumes: host cycle starts with ads_n low for one clock; bus clock is clk
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - drive data driven only during write strobe
// - drive bits 7..0 low byte, 15..8 high
// - whole port except drive reset works only while enable high
// - host bus 32 bits, byte enables pick lanes
// - host data driven only in read T2
// - interrupt follows drive irq when enabled, else floats
// - claim output decoded from address and qualifiers
// - ready: drive high, low one state, high, release
// - mode select high means pci mode
// - track cpu ready to stay in step
// - write/read and memory/io qualifiers steer handling
// - clocked by host clock, reset by srst; cpu reset pin only feeds drive reset
// - claim only i/o, not acknowledge or halt
// - drive reset is a registered copy of host reset
// - extend cycle while drive ready low
// - drive strobes high when inactive
module lbide_host_port (
    input wire logic clk,                        // host bus clock
    input wire logic srst,                       // reset, active high
    input wire logic host_reset_n,               // cpu reset pin
    input wire logic bus_mode_select,            // high selects pci mode
    input wire logic controller_enable_in,       // high enables port
    input wire logic [13:0] host_address_bus,    // host address 15..2
    input wire logic [3:0] host_byte_enables_n,  // byte lanes, active low
    input wire logic memory_io_qualifier,        // high memory, low i/o
    input wire logic data_control_qualifier,     // high data, low ack/halt
    input wire logic write_read_qualifier,       // high write
    input wire logic ads_n,                      // cycle start, active low
    input wire logic cpu_ready_n,                // cpu ready, active low
    input wire logic [31:0] host_data_in,        // host data pins in
    output logic [31:0] host_data_out,           // host data pins out
    output logic host_data_oe,                   // host data drive enable
    output logic local_device_claim_n,           // claim out, low active
    output logic local_device_claim_oe,          // claim drive enable
    output logic local_ready_n,                  // ready out, low active
    output logic local_ready_oe,                 // ready drive enable
    output logic irq_out,                        // system interrupt level
    output logic irq_oe,                         // interrupt drive enable
    input wire logic drive_interrupt_in,         // drive interrupt
    input wire logic drive_ready_in,             // drive ready
    input wire logic [15:0] drive_data_in,       // drive data pins in
    output logic [15:0] drive_data_out,          // drive data pins out
    output logic drive_data_oe,                  // drive data enable
    output logic drive_read_strobe_n,            // drive read strobe
    output logic drive_write_strobe_n,           // drive write strobe
    output logic drive_reset_n                   // drive reset
);
    ////////////////////////////////////////////////////////////////////////////
    lbide_pkg::lbide_state_t state_q;
    logic [lbide_pkg::LBIDE_CNT_W-1:0] cnt_q;
    logic active;
    logic hit;
    logic is_write_q;
    logic upper_q;
    logic [3:0] be_q;
    logic [31:0] wdata_q;
    logic [15:0] lane_word;
    logic lane_any;
    logic [15:0] lane_word_q;

    // vl mode and enable pin together gate everything but drive reset
    assign active = ~bus_mode_select & controller_enable_in;
    // only i/o data cycles to our ports are claimed
    assign hit = active & ~memory_io_qualifier & data_control_qualifier
        & ((host_address_bus[13:1] == lbide_pkg::LBIDE_BASE_CMD[13:1])
           | (host_address_bus == lbide_pkg::LBIDE_BASE_CTL));

    lbide_lane u_lane (
        .host_wdata(wdata_q),
        .be_n(be_q),
        .upper(upper_q),
        .word(lane_word),
        .any_lane(lane_any)
    );

    ////////////////////////////////////////////////////////////////////////////
    // claim output registered so the glitch window stays inside one clock
    always_ff @(posedge clk) begin
        if (srst) begin
            local_device_claim_n <= 1'b1;
            local_device_claim_oe <= 1'b0;
        end else begin
            local_device_claim_n <= ~hit;
            local_device_claim_oe <= hit;
        end
    end

    // interrupt follows drive line, floats when disabled
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_out <= 1'b0;
            irq_oe <= 1'b0;
        end else begin
            irq_out <= drive_interrupt_in;
            irq_oe <= active;
        end
    end

    // drive reset copies the cpu reset pin
    always_ff @(posedge clk) begin
        if (srst) begin
            drive_reset_n <= 1'b0;
        end else begin
            drive_reset_n <= host_reset_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // cycle sequencer: strobe, wait drive ready, then ready handshake
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= lbide_pkg::LBIDE_IDLE;
            cnt_q <= '0;
            is_write_q <= 1'b0;
            upper_q <= 1'b0;
            be_q <= 4'hf;
            wdata_q <= 32'h0000_0000;
        end else if (!active) begin
            state_q <= lbide_pkg::LBIDE_IDLE;
        end else begin
            case (state_q)
                lbide_pkg::LBIDE_IDLE: begin
                    if (!ads_n && hit && !(&host_byte_enables_n)) begin
                        state_q <= lbide_pkg::LBIDE_STRB;
                        cnt_q <= 4'(lbide_pkg::LBIDE_ACTIVE_CYC - 1);
                        is_write_q <= write_read_qualifier;
                        upper_q <= host_byte_enables_n[1:0] == 2'b11;
                        be_q <= host_byte_enables_n;
                        wdata_q <= host_data_in;
                    end
                end
                lbide_pkg::LBIDE_STRB: begin
                    if (cnt_q != '0) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (drive_ready_in) begin
                        state_q <= lbide_pkg::LBIDE_HI1;
                    end else begin
                        state_q <= lbide_pkg::LBIDE_WAIT;
                    end
                end
                lbide_pkg::LBIDE_WAIT: begin
                    if (drive_ready_in) begin
                        state_q <= lbide_pkg::LBIDE_HI1;
                    end
                end
                lbide_pkg::LBIDE_HI1: state_q <= lbide_pkg::LBIDE_LO;
                lbide_pkg::LBIDE_LO: state_q <= lbide_pkg::LBIDE_HI2;
                lbide_pkg::LBIDE_HI2: state_q <= lbide_pkg::LBIDE_IDLE;
                default: state_q <= lbide_pkg::LBIDE_IDLE;
            endcase
            // cpu ready seen while busy means the host moved on: resync
            // only the strobe phase aborts: a launched ready pulse runs to its end
            if (!cpu_ready_n && (state_q == lbide_pkg::LBIDE_STRB
                || state_q == lbide_pkg::LBIDE_WAIT)) begin
                state_q <= lbide_pkg::LBIDE_IDLE;
            end
        end
    end

    // sample the drive word on every strobe cycle; the last one is held
    always_ff @(posedge clk) begin
        if (srst) begin
            lane_word_q <= 16'h0000;
        end else if (state_q == lbide_pkg::LBIDE_STRB || state_q == lbide_pkg::LBIDE_WAIT) begin
            lane_word_q <= drive_data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // drive strobes and data, idle high / released
    always_ff @(posedge clk) begin
        if (srst) begin
            drive_read_strobe_n <= 1'b1;
            drive_write_strobe_n <= 1'b1;
            drive_data_out <= 16'h0000;
            drive_data_oe <= 1'b0;
        end else begin
            drive_read_strobe_n <= ~(active && !is_write_q && lane_any
                && (state_q == lbide_pkg::LBIDE_STRB || state_q == lbide_pkg::LBIDE_WAIT)
                && cpu_ready_n);
            drive_write_strobe_n <= ~(active && is_write_q && lane_any
                && (state_q == lbide_pkg::LBIDE_STRB || state_q == lbide_pkg::LBIDE_WAIT)
                && cpu_ready_n);
            drive_data_out <= lane_word;
            drive_data_oe <= active && is_write_q && lane_any && cpu_ready_n
                && (state_q == lbide_pkg::LBIDE_STRB || state_q == lbide_pkg::LBIDE_WAIT);
        end
    end

    // local ready: driven high, low for one state, high, then released
    always_ff @(posedge clk) begin
        if (srst) begin
            local_ready_n <= 1'b1;
            local_ready_oe <= 1'b0;
        end else begin
            local_ready_n <= ~(active && state_q == lbide_pkg::LBIDE_HI1);
            local_ready_oe <= active && (((state_q == lbide_pkg::LBIDE_STRB
                || state_q == lbide_pkg::LBIDE_WAIT) && cpu_ready_n)
                || state_q == lbide_pkg::LBIDE_HI1 || state_q == lbide_pkg::LBIDE_LO);
        end
    end

    // host data driven only in read T2 (ready low state), word on both halves
    always_ff @(posedge clk) begin
        if (srst) begin
            host_data_out <= 32'h0000_0000;
            host_data_oe <= 1'b0;
        end else begin
            host_data_out <= {lane_word_q, lane_word_q};
            host_data_oe <= active && !is_write_q && state_q == lbide_pkg::LBIDE_HI1;
        end
    end
endmodule

// ### lbide_checker.sv
// lbide_checker: pin checks of the host port
// assumes: bound to lbide_host_port, one clock, srst sync high
`timescale 1ns/1ps
module lbide_checker (
    input wire logic clk, // clock
    input wire logic srst, // reset
    input wire logic host_reset_n, // cpu reset
    input wire logic bus_mode_select, // pci mode
    input wire logic controller_enable_in, // enable
    input wire logic memory_io_qualifier, // memory
    input wire logic data_control_qualifier, // data
    input wire logic cpu_ready_n, // cpu ready
    input wire logic host_data_oe, // host oe
    input wire logic local_device_claim_oe, // claim oe
    input wire logic local_ready_n, // ready
    input wire logic local_ready_oe, // ready oe
    input wire logic irq_out, // irq
    input wire logic irq_oe, // irq oe
    input wire logic drive_interrupt_in, // drive irq
    input wire logic drive_ready_in, // drive ready
    input wire logic drive_data_oe, // drive oe
    input wire logic drive_write_strobe_n, // write strobe
    input wire logic drive_read_strobe_n, // read strobe
    input wire logic drive_reset_n // drive reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////////
    // bus enables, ready shape and decode; $past guarded after reset in irq and drive reset checks only
    property p_dd_oe; drive_data_oe |-> !drive_write_strobe_n; endproperty
    property p_hd_oe; host_data_oe |-> !local_ready_n && local_ready_oe; endproperty
    property p_off;
        (!controller_enable_in)[*2] |-> !(local_device_claim_oe || local_ready_oe || host_data_oe);
    endproperty
    property p_irq; !$past(srst) && $past(controller_enable_in) && !$past(bus_mode_select)
        |-> irq_oe && irq_out == $past(drive_interrupt_in); endproperty
    property p_irq_off; !$past(srst) && !$past(controller_enable_in) |-> !irq_oe; endproperty
    property p_rdy; $fell(local_ready_n) |-> $past(local_ready_oe) ##1
        local_ready_n && local_ready_oe ##1 !local_ready_oe; endproperty
    property p_ext; !drive_read_strobe_n && !drive_ready_in && cpu_ready_n
        |=> !drive_read_strobe_n; endproperty
    property p_rst; !$past(srst) |-> drive_reset_n == $past(host_reset_n); endproperty
    property p_claim;
        local_device_claim_oe |-> $past(!memory_io_qualifier && data_control_qualifier);
    endproperty
    a_dd_oe: assert property (p_dd_oe) else $error("drive bus driven off strobe");
    a_hd_oe: assert property (p_hd_oe) else $error("host bus driven off T2");
    a_off: assert property (p_off) else $error("active while disabled");
    a_irq: assert property (p_irq) else $error("irq does not track");
    a_irq_off: assert property (p_irq_off) else $error("irq driven while off");
    a_rdy: assert property (p_rdy) else $error("ready pulse shape");
    a_ext: assert property (p_ext) else $error("strobe ended early");
    a_rst: assert property (p_rst) else $error("drive reset wrong");
    a_claim: assert property (p_claim) else $error("claimed a non-io cycle");
    c_wr: cover property ($fell(drive_write_strobe_n));
    c_rd: cover property ($fell(drive_read_strobe_n));
    c_ext: cover property (!drive_read_strobe_n && !drive_ready_in);
endmodule

// ### lbide_drive_model.sv
// lbide_drive_model: behavioural drive on the drive pins
// assumes: strobes active low; bench sets stall and read word
`timescale 1ns/1ps
module lbide_drive_model (
    input wire logic clk, // clock
    input wire logic rd_n, // read strobe
    input wire logic wr_n, // write strobe
    input wire logic [15:0] wdata, // port data
    input wire logic wdata_oe, // port drives
    input wire logic [15:0] rword, // word to return
    input wire logic [3:0] stall, // ready low cycles
    output logic [15:0] rdata, // data to port
    output logic ready, // drive ready
    output logic [15:0] got // last written
);
    logic [3:0] cnt_q = 4'h0;
    logic [15:0] last_q = 16'h0;
    ////////////////////////////////////////////////////////////////////////////////
    // ready low for stall cycles once a strobe falls
    always_ff @(posedge clk) begin
        if (rd_n && wr_n) cnt_q <= stall;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
    assign ready = (rd_n && wr_n) || cnt_q == 4'h0;
    // released bus toggles so a stale value cannot pass
    always_ff @(posedge clk) begin
        if (!wr_n && wdata_oe) got <= wdata;
        last_q <= rdata;
    end
    assign rdata = rd_n ? ~last_q : rword;
endmodule

// ### lbide_host_port_tb.sv
// lbide_host_port_tb: random and corner host cycles against a drive model
// assumes: design, checker and model compiled first; 125 MHz clock
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
    $display("unexpected t=%0t got %h want %h", $time, a, e); end end
module lbide_host_port_tb;
    logic clk = 0, srst = 1, host_reset_n = 0, bus_mode_select = 0, controller_enable_in = 1;
    logic memory_io_qualifier = 0, data_control_qualifier = 1, write_read_qualifier = 0;
    logic ads_n = 1, cpu_ready_n = 1, drive_interrupt_in = 0, drive_ready_in;
    logic host_data_oe, local_device_claim_n, local_device_claim_oe, local_ready_n;
    logic local_ready_oe, irq_out, irq_oe, drive_data_oe, drive_read_strobe_n;
    logic drive_write_strobe_n, drive_reset_n;
    logic [13:0] host_address_bus = 14'h0;
    logic [3:0] host_byte_enables_n = 4'hf, stall = 4'h0;
    logic [31:0] host_data_in = 32'h0, host_data_out, r;
    logic [15:0] drive_data_in, drive_data_out, rword = 16'h0, got;
    int errors = 0, cmp_count = 0, cycles = 0;
    integer seed = 32'hbd8df703;
    lbide_host_port dut_u (.*);
    lbide_drive_model drv_u (.clk(clk), .rd_n(drive_read_strobe_n), .wr_n(drive_write_strobe_n),
        .wdata(drive_data_out), .wdata_oe(drive_data_oe), .rword(rword), .stall(stall),
        .rdata(drive_data_in), .ready(drive_ready_in), .got(got));
    ////////////////////////////////////////////////////////////////////////////////
    // clock, then a cycle ceiling that stops a hang
    initial begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        {drive_interrupt_in, host_reset_n} <= 2'($random(seed));
        if (cycles > 4000) begin errors++; stop_test(); end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // expected drive word: low half if lane 0 or 1 picked, unpicked bytes zero
    function automatic logic [15:0] exp_word(logic [31:0] d, logic [3:0] be);
        logic [31:0] m;
        m = d & {{8{~be[3]}}, {8{~be[2]}}, {8{~be[1]}}, {8{~be[0]}}};
        return (be[1:0] != 2'b11) ? m[15:0] : m[31:16];
    endfunction
    // claim depends on address, qualifiers, enable and mode only, byte enables play no part
    function automatic logic claim();
        return controller_enable_in && !bus_mode_select && !memory_io_qualifier &&
            data_control_qualifier &&
            (host_address_bus == lbide_pkg::LBIDE_BASE_CTL ||
            host_address_bus[13:1] == lbide_pkg::LBIDE_BASE_CMD[13:1]);
    endfunction
    // one host cycle; ready must come exactly when the cycle is ours
    // abort pulses cpu ready mid-strobe: the port must drop the strobe and stay quiet
    task automatic host_cycle(input bit abort);
        logic want;
        int n;
        want = claim() && host_byte_enables_n != 4'hf && !abort;
        n = 0;
        @(posedge clk) #1 ads_n = 0;
        @(posedge clk) #1 ads_n = 1;
        // claim sampled two clocks after the address settled, past any glitch
        `CHK({local_device_claim_n, local_device_claim_oe}, {!claim(), claim()})
        if (abort) begin
            @(posedge clk) #1 cpu_ready_n = 0;
            @(posedge clk) #1 cpu_ready_n = 1;
            `CHK(drive_read_strobe_n & drive_write_strobe_n, 1'b1)
        end
        while (!(local_ready_oe === 1'b1 && local_ready_n === 1'b0) && n < 24) begin
            @(posedge clk) #1 n++;
        end
        `CHK(n < 24, want)
        if (want && write_read_qualifier)
            `CHK(got, exp_word(host_data_in, host_byte_enables_n))
        else if (want) begin
            `CHK(host_data_out, {rword, rword})
            `CHK(host_data_oe, 1'b1)
        end
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic stop_test();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // four corners (all lanes with stall, top lane only, no lane, cpu abort), then random
    initial begin
        repeat (5) @(posedge clk);
        #1 srst = 0;
        for (int i = 0; i < 44; i++) begin
            // mid-run reset between cycles: drive reset low, read strobe idle, ready released
            if (i == 22) begin
                srst = 1;
                @(posedge clk) #1 srst = 0;
                `CHK({drive_reset_n, local_ready_oe, drive_read_strobe_n}, 3'b001)
            end
            r = $random(seed);
            host_address_bus = r[2] ? r[31:18] : (r[1] ? lbide_pkg::LBIDE_BASE_CTL :
                lbide_pkg::LBIDE_BASE_CMD + {13'h0, r[0]});
            {host_byte_enables_n, write_read_qualifier} = r[7:3];
            memory_io_qualifier = r[8] & r[9];
            data_control_qualifier = r[10] | r[11];
            controller_enable_in = r[12] | r[13] | r[14];
            bus_mode_select = r[15] & r[16];
            stall = {1'b0, r[19:17]};
            host_data_in = $random(seed);
            rword = 16'($random(seed));
            if (i < 4) begin
                {controller_enable_in, bus_mode_select, memory_io_qualifier} = 3'b100;
                {data_control_qualifier, stall} = {1'b1, 4'h6};
                host_address_bus = lbide_pkg::LBIDE_BASE_CMD;
                write_read_qualifier = i[0];
                host_byte_enables_n = i == 1 ? 4'h7 : (i == 2 ? 4'hf : 4'h0);
            end
            host_cycle(i == 3);
        end
        stop_test();
    end
endmodule
bind lbide_host_port lbide_checker chk_u (.*);
